// [snmsp_pkg.sv]
// shared constants for the serial byte-memory port: timing, opcodes,
// status layout and protection ranges.
// assumes both ends run on one 20 MHz core clock.
package snmsp_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCK_PERIOD_NS = 400;
    localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int MAX_SCK_HZ = 16_000_000;
    localparam int MEM_DEPTH = 8192;
    localparam int ADDR_W = 13;
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    // opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    // status register layout
    localparam int GUARD_HONOR_BIT = 7;
    localparam int SR_PROT_HI = 3;
    localparam int SR_PROT_LO = 2;
    localparam int SR_LATCH_BIT = 1;
    localparam logic [7:0] SR_WR_MASK = 8'h8C;
    localparam logic [7:0] SR_RESET = 8'h00;
    // protection ranges
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;
    localparam logic [12:0] QUARTER_BASE = 13'h1800;
    localparam logic [12:0] HALF_BASE = 13'h1000;
    // command lengths in bits
    localparam logic [5:0] LEN_CMD = 6'h08;
    localparam logic [5:0] LEN_STAT = 6'h10;
    localparam logic [5:0] LEN_MEM = 6'h20;
endpackage

// [snmsp_if.sv]
// serial link between the memory device end and the master end.
// assumes so carries meaning only while so_oe_n is low.
`timescale 1ns/1ps
interface snmsp_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe_n;
    logic hold_n;
    logic wp_n;

    modport dev (input sck, input cs_n, input si, input hold_n, input wp_n,
                 output so, output so_oe_n);
    modport host (output sck, output cs_n, output si, output hold_n,
                  output wp_n, input so, input so_oe_n);
endinterface

// [snmsp_device.sv]
// memory device end of the serial link: 8192 x 8 array, status register,
// protection and pause handling.
// assumes link pins arrive asynchronously and are sampled by CORE_CLK.
`timescale 1ns/1ps
// Behaviour
// - deselected: idle, ignore inputs, output off
// - master drops select before each command
// - sample input on rise, change output on fall
// - any clock rate well under half the core clock, stops without state loss
// - output driven only for read data
// - guard bit and low pin block status writes
// - pause freezes command position
// - pause ignores clock and select edges
// - master changes pause only while clock low
// - clock modes 0 and 3 only
// - each data byte stored at its last bit
// - block protect quarter, half or whole
// - 8192 byte locations, byte access
// - master may join input and output lines
// - first byte after select is command
// - two address bytes, top 3 bits ignored
// - unknown command ignores rest until reselect
// - most significant bit first
module snmsp_device #(
    parameter int DEPTH = snmsp_pkg::MEM_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    snmsp_if.dev BUS,
    output logic [7:0] STATUS,
    output logic SELECTED,
    output logic PAUSED
);
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_CMD = 9'h002,
        ST_ADRH = 9'h004,
        ST_ADRL = 9'h008,
        ST_WDAT = 9'h010,
        ST_RDAT = 9'h020,
        ST_WSTA = 9'h040,
        ST_RSTA = 9'h080,
        ST_SKIP = 9'h100
    } snmsp_dstate_t;

    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic sck_d_r;
    logic cs_eff_r, cs_eff_nxt;
    snmsp_dstate_t state_r, state_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [12:0] addr_r, addr_nxt;
    logic [7:0] out_r, out_nxt;
    logic so_r, so_nxt;
    logic drive_r, drive_nxt;
    logic so_oe_n_r, so_oe_n_nxt;
    logic is_rd_r, is_rd_nxt;
    logic drop_r, drop_nxt;
    logic [7:0] sr_r, sr_nxt;
    logic sel_r, paused_r;
    logic mem_we;
    logic [7:0] mem_r [DEPTH];

    logic sck_s, cs_s, si_s, hold_s, wp_s;
    logic rise, fall, cs_fall, cs_rise;
    logic [7:0] byte_in;
    logic [12:0] adr_full;

    assign sck_s = sync2_r[4];
    assign cs_s = sync2_r[3];
    assign si_s = sync2_r[2];
    assign hold_s = sync2_r[1];
    assign wp_s = sync2_r[0];
    assign byte_in = {sh_r[6:0], si_s};
    assign adr_full = {addr_r[12:8], byte_in};

    assign BUS.so = so_r;
    assign BUS.so_oe_n = so_oe_n_r;
    assign STATUS = sr_r;
    assign SELECTED = sel_r;
    assign PAUSED = paused_r;

    function automatic logic guarded(input logic [1:0] prot, input logic [12:0] a);
        case (prot)
            snmsp_pkg::PROT_NONE: guarded = 1'b0;
            snmsp_pkg::PROT_QUARTER: guarded = (a >= snmsp_pkg::QUARTER_BASE);
            snmsp_pkg::PROT_HALF: guarded = (a >= snmsp_pkg::HALF_BASE);
            default: guarded = 1'b1;
        endcase
    endfunction

    // pins are asynchronous; the link clock is just another sampled input.
    // limitation: the core must run well over twice the link clock.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            // link clock starts at its mode 0 idle low, so no false rise
            sync1_r <= 5'h0B;
            sync2_r <= 5'h0B;
        end else begin
            sync1_r <= {BUS.sck, BUS.cs_n, BUS.si, BUS.hold_n, BUS.wp_n};
            sync2_r <= sync1_r;
        end
    end

    always_comb begin
        // edges only count while not paused
        rise = hold_s && sck_s && !sck_d_r;
        fall = hold_s && !sck_s && sck_d_r;
        cs_eff_nxt = hold_s ? cs_s : cs_eff_r;
        cs_fall = cs_eff_r && !cs_eff_nxt;
        cs_rise = !cs_eff_r && cs_eff_nxt;
        state_nxt = state_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        out_nxt = out_r;
        so_nxt = so_r;
        drive_nxt = drive_r;
        is_rd_nxt = is_rd_r;
        drop_nxt = drop_r;
        sr_nxt = sr_r;
        mem_we = 1'b0;
        if (cs_fall) begin
            // fresh select starts a command
            state_nxt = ST_CMD;
            bit_nxt = snmsp_pkg::BIT_FIRST;
            drive_nxt = 1'b0;
            drop_nxt = 1'b0;
        end else if (cs_eff_nxt) begin
            // deselected: standby, output off
            state_nxt = ST_IDLE;
            drive_nxt = 1'b0;
            if (cs_rise && drop_r) begin
                sr_nxt[snmsp_pkg::SR_LATCH_BIT] = 1'b0;
            end
            drop_nxt = 1'b0;
        end else begin
            // state only moves on edges, so a stopped clock loses nothing
            if (rise && state_r != ST_IDLE && state_r != ST_SKIP) begin
                sh_nxt = byte_in;
                bit_nxt = bit_r + 3'h1;
                if (bit_r == snmsp_pkg::BIT_LAST) begin
                    case (state_r)
                        ST_CMD: begin
                            case (byte_in)
                                snmsp_pkg::OP_SET_LATCH: begin
                                    sr_nxt[snmsp_pkg::SR_LATCH_BIT] = 1'b1;
                                    state_nxt = ST_SKIP;
                                end
                                snmsp_pkg::CLEAR_WRITE_LATCH_CMD: begin
                                    sr_nxt[snmsp_pkg::SR_LATCH_BIT] = 1'b0;
                                    state_nxt = ST_SKIP;
                                end
                                snmsp_pkg::OP_RD_STATUS: begin
                                    out_nxt = sr_r;
                                    state_nxt = ST_RSTA;
                                end
                                snmsp_pkg::OP_WR_STATUS: state_nxt = ST_WSTA;
                                snmsp_pkg::OP_READ, snmsp_pkg::OP_WRITE: begin
                                    is_rd_nxt = (byte_in == snmsp_pkg::OP_READ);
                                    state_nxt = ST_ADRH;
                                end
                                default: state_nxt = ST_SKIP;
                            endcase
                        end
                        ST_ADRH: begin
                            addr_nxt = {byte_in[4:0], addr_r[7:0]};
                            state_nxt = ST_ADRL;
                        end
                        ST_ADRL: begin
                            if (is_rd_r) begin
                                out_nxt = mem_r[adr_full];
                                addr_nxt = adr_full + 13'h0001;
                                state_nxt = ST_RDAT;
                            end else begin
                                addr_nxt = adr_full;
                                state_nxt = ST_WDAT;
                            end
                        end
                        ST_WDAT: begin
                            // stored at once, no busy time
                            mem_we = sr_r[snmsp_pkg::SR_LATCH_BIT]
                                && !guarded(sr_r[snmsp_pkg::SR_PROT_HI:snmsp_pkg::SR_PROT_LO],
                                            addr_r);
                            addr_nxt = addr_r + 13'h0001;
                            drop_nxt = 1'b1;
                        end
                        ST_RDAT: begin
                            out_nxt = mem_r[addr_r];
                            addr_nxt = addr_r + 13'h0001;
                        end
                        ST_WSTA: begin
                            if (sr_r[snmsp_pkg::SR_LATCH_BIT]
                                && !(sr_r[snmsp_pkg::GUARD_HONOR_BIT] && !wp_s)) begin
                                sr_nxt = (sr_r & ~snmsp_pkg::SR_WR_MASK)
                                    | (byte_in & snmsp_pkg::SR_WR_MASK);
                            end
                            drop_nxt = 1'b1;
                            state_nxt = ST_SKIP;
                        end
                        ST_RSTA: out_nxt = sr_r;
                        default: state_nxt = ST_SKIP;
                    endcase
                end
            end
            if (fall && (state_r == ST_RDAT || state_r == ST_RSTA)) begin
                so_nxt = out_r[7];
                out_nxt = {out_r[6:0], 1'b0};
                drive_nxt = 1'b1;
            end
        end
        // output also released while paused
        so_oe_n_nxt = !(drive_nxt && hold_s);
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sck_d_r <= 1'b0;
            cs_eff_r <= 1'b1;
            state_r <= ST_IDLE;
            bit_r <= snmsp_pkg::BIT_FIRST;
            sh_r <= 8'h00;
            addr_r <= 13'h0000;
            out_r <= 8'h00;
            so_r <= 1'b0;
            drive_r <= 1'b0;
            so_oe_n_r <= 1'b1;
            is_rd_r <= 1'b0;
            drop_r <= 1'b0;
            sr_r <= snmsp_pkg::SR_RESET;
            sel_r <= 1'b0;
            paused_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
            cs_eff_r <= cs_eff_nxt;
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            out_r <= out_nxt;
            so_r <= so_nxt;
            drive_r <= drive_nxt;
            so_oe_n_r <= so_oe_n_nxt;
            is_rd_r <= is_rd_nxt;
            drop_r <= drop_nxt;
            sr_r <= sr_nxt;
            sel_r <= !cs_eff_nxt;
            paused_r <= !hold_s;
        end
    end

    // array is nonvolatile in spirit: no reset
    always_ff @(posedge CORE_CLK) begin
        if (mem_we) begin
            mem_r[addr_r] <= byte_in;
        end
    end
endmodule

// [snmsp_host.sv]
// master end of the serial link: runs one command per start request in
// mode 0, making the link clock from the core clock by a divider.
// assumes the user holds request fields steady while busy.
`timescale 1ns/1ps
module snmsp_host #(
    parameter int HALF_CYC = snmsp_pkg::SCK_HALF_CYC
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    snmsp_if.host BUS,
    input wire logic USR_START,
    input wire logic [7:0] USR_CMD,
    input wire logic [15:0] USR_ADDR,
    input wire logic [7:0] USR_WDATA,
    input wire logic USR_PAUSE,
    input wire logic USR_WP_N,
    output logic USR_BUSY,
    output logic USR_DONE,
    output logic [7:0] USR_RDATA
);
    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_LOW = 5'h02,
        HS_HIGH = 5'h04,
        HS_END = 5'h08,
        HS_GAP = 5'h10
    } snmsp_hstate_t;

    snmsp_hstate_t st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [5:0] left_r, left_nxt;
    logic [31:0] tx_r, tx_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic sck_r, sck_nxt;
    logic cs_n_r, cs_n_nxt;
    logic si_r, si_nxt;
    logic hold_n_r, hold_n_nxt;
    logic wp_n_r;
    logic done_r, done_nxt;
    logic busy_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic miso1_r, miso2_r;
    logic half_end;
    logic [5:0] len;
    logic [31:0] frame;

    assign BUS.sck = sck_r;
    assign BUS.cs_n = cs_n_r;
    assign BUS.si = si_r;
    assign BUS.hold_n = hold_n_r;
    assign BUS.wp_n = wp_n_r;
    assign USR_BUSY = busy_r;
    assign USR_DONE = done_r;
    assign USR_RDATA = rdata_r;

    always_comb begin
        // opcode always leads the frame
        case (USR_CMD)
            snmsp_pkg::OP_RD_STATUS, snmsp_pkg::OP_WR_STATUS: begin
                len = snmsp_pkg::LEN_STAT;
                frame = {USR_CMD, USR_WDATA, 16'h0000};
            end
            snmsp_pkg::OP_READ, snmsp_pkg::OP_WRITE: begin
                len = snmsp_pkg::LEN_MEM;
                frame = {USR_CMD, USR_ADDR, USR_WDATA};
            end
            default: begin
                len = snmsp_pkg::LEN_CMD;
                frame = {USR_CMD, 24'h000000};
            end
        endcase
    end

    always_comb begin
        half_end = (cnt_r == 8'(HALF_CYC - 1));
        st_nxt = st_r;
        cnt_nxt = cnt_r + 8'h01;
        left_nxt = left_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        sck_nxt = sck_r;
        cs_n_nxt = cs_n_r;
        si_nxt = si_r;
        hold_n_nxt = hold_n_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (st_r)
            HS_IDLE: begin
                cnt_nxt = 8'h00;
                if (USR_START) begin
                    // each command gets its own select fall
                    cs_n_nxt = 1'b0;
                    tx_nxt = frame;
                    si_nxt = frame[31];
                    left_nxt = len;
                    st_nxt = HS_LOW;
                end
            end
            HS_LOW: begin
                // pause only moves with the clock low
                hold_n_nxt = !USR_PAUSE;
                if (USR_PAUSE || !hold_n_r) begin
                    cnt_nxt = 8'h00;
                end else if (half_end) begin
                    sck_nxt = 1'b1; // mode 0 idles low
                    cnt_nxt = 8'h00;
                    st_nxt = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (half_end) begin
                    // sample late in the high half, after the device's fall update
                    rx_nxt = {rx_r[6:0], miso2_r};
                    sck_nxt = 1'b0;
                    cnt_nxt = 8'h00;
                    left_nxt = left_r - 6'h01;
                    tx_nxt = {tx_r[30:0], 1'b0};
                    si_nxt = tx_r[30];
                    st_nxt = (left_r == 6'h01) ? HS_END : HS_LOW;
                end
            end
            HS_END: begin
                if (half_end) begin
                    cs_n_nxt = 1'b1;
                    cnt_nxt = 8'h00;
                    rdata_nxt = rx_r;
                    st_nxt = HS_GAP;
                end
            end
            HS_GAP: begin
                // deselect long enough for the device to see it
                if (half_end) begin
                    done_nxt = 1'b1;
                    st_nxt = HS_IDLE;
                end
            end
            default: st_nxt = HS_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_r <= HS_IDLE;
            cnt_r <= 8'h00;
            left_r <= 6'h00;
            tx_r <= 32'h00000000;
            rx_r <= 8'h00;
            sck_r <= 1'b0;
            cs_n_r <= 1'b1;
            si_r <= 1'b0;
            hold_n_r <= 1'b1;
            wp_n_r <= 1'b1;
            done_r <= 1'b0;
            busy_r <= 1'b0;
            rdata_r <= 8'h00;
            miso1_r <= 1'b0;
            miso2_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            left_r <= left_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            sck_r <= sck_nxt;
            cs_n_r <= cs_n_nxt;
            si_r <= si_nxt;
            hold_n_r <= hold_n_nxt;
            wp_n_r <= USR_WP_N;
            done_r <= done_nxt;
            busy_r <= (st_nxt != HS_IDLE);
            rdata_r <= rdata_nxt;
            // undriven line reads as low through the enable
            miso1_r <= BUS.so & !BUS.so_oe_n;
            miso2_r <= miso1_r;
        end
    end
endmodule

// [snmsp_checker.sv]
// assertions on the serial link joining the memory end and the master end.
// assumes the master runs mode 0 with a 4-cycle half period, and a 2-flop pin sync plus output register in the device.
`timescale 1ns/1ps
module snmsp_checker (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic hold_n,
    input wire logic wp_n
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);

    logic [5:0] rise_cnt_r;
    logic [5:0] rise_cnt_nxt;
    logic sck_d_r;

    // counts clock rises inside one select window
    always_comb begin
        rise_cnt_nxt = rise_cnt_r;
        if (cs_n) begin
            rise_cnt_nxt = rise_cnt_r;
        end else if (sck && !sck_d_r) begin
            rise_cnt_nxt = rise_cnt_r + 6'h01;
        end
        if (cs_n && sck_d_r) begin
            rise_cnt_nxt = 6'h00;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || ($fell(cs_n))) begin
            rise_cnt_r <= 6'h00;
        end else begin
            rise_cnt_r <= rise_cnt_nxt;
        end
        sck_d_r <= sck;
    end

    sequence s_frame_open;
        $fell(cs_n);
    endsequence
    sequence s_setup_gap;
        !sck [*4];
    endsequence
    sequence s_drive_rise;
        $rose(sck) ##0 !so_oe_n;
    endsequence

    chk_select_then_clock: assert property (s_frame_open |-> s_setup_gap)
        else $error("link clock rose too soon after select fell");
    chk_deselect_out_off: assert property (cs_n [*5] |-> so_oe_n)
        else $error("output driven while deselected");
    chk_pause_out_off: assert property (!hold_n [*5] |-> so_oe_n)
        else $error("output driven during pause");
    chk_out_after_fall: assert property ((!so_oe_n && $changed(so))
        |-> (!$past(sck, 3) && $past(sck, 4)))
        else $error("output changed away from a clock fall");
    chk_out_held_high: assert property (s_drive_rise |=> $stable(so) [*3])
        else $error("output moved during clock high phase");
    chk_pause_clock_low: assert property ($changed(hold_n) |-> !sck)
        else $error("pause changed while clock high");
    chk_pause_frozen: assert property ((!hold_n && !$past(hold_n))
        |-> ($stable(sck) && $stable(cs_n) && $stable(si)))
        else $error("link moved during pause");
    chk_pause_no_shift: assert property (!hold_n [*5] |-> $stable(so))
        else $error("output shifted during pause");
    chk_idle_clock_low: assert property ((cs_n && $past(cs_n)) |-> !sck)
        else $error("clock not idle low outside frame");
    chk_frame_bit_count: assert property ($rose(cs_n)
        |-> (rise_cnt_r inside {6'h08, 6'h10, 6'h20}))
        else $error("frame length not 8, 16 or 32 bits");
    cover property ($fell(hold_n));
endmodule

// [snmsp_tb.sv]
// self-checking bench: master end drives the memory end over the link.
// assumes the package opcodes and status layout; array contents start unknown.
`timescale 1ns/1ps
module snmsp_tb;
    logic core_clk;
    logic sys_rst;
    logic usr_start;
    logic usr_pause;
    logic usr_wp_n;
    logic [7:0] usr_cmd;
    logic [15:0] usr_addr;
    logic [7:0] usr_wdata;
    logic usr_busy;
    logic usr_done;
    logic [7:0] usr_rdata;
    logic [7:0] status;
    logic selected;
    logic paused;
    int n_mismatch;
    int checks_done;
    // row: cmd, addr, wdata, expected read, wp_n, compare flag
    localparam int NROWS = 45;
    logic [47:0] rows [NROWS] = '{
        48'h060000000010, 48'h020010A50010, 48'h060000000010, 48'h021FFF3C0010,
        48'h060000000010, 48'h021000660010, 48'h03001000A511, 48'h03E01000A511,
        48'h031FFF003C11, 48'h050000000011, 48'h020010FF0010, 48'h03001000A511,
        48'h060000000010, 48'h040000000010, 48'h020010FF0010, 48'h03001000A511,
        48'hAB0000000011, 48'h060000000010, 48'h010000040010, 48'h050000000411,
        48'h060000000010, 48'h021FFF770010, 48'h031FFF003C11, 48'h060000000010,
        48'h0200105A0010, 48'h030010005A11, 48'h060000000010, 48'h010000080010,
        48'h060000000010, 48'h021000110010, 48'h031000006611, 48'h060000000010,
        48'h0100000C0010, 48'h060000000010, 48'h020010220010, 48'h030010005A11,
        48'h060000000010, 48'h010000800010, 48'h050000008011, 48'h060000000000,
        48'h010000000000, 48'h050000008001, 48'h060000000010, 48'h010000000010,
        48'h050000000011
    };

    snmsp_if bus ();
    snmsp_device snmsp_device_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .BUS(bus.dev),
        .STATUS(status), .SELECTED(selected), .PAUSED(paused));
    snmsp_host snmsp_host_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .BUS(bus.host),
        .USR_START(usr_start), .USR_CMD(usr_cmd), .USR_ADDR(usr_addr),
        .USR_WDATA(usr_wdata), .USR_PAUSE(usr_pause), .USR_WP_N(usr_wp_n),
        .USR_BUSY(usr_busy), .USR_DONE(usr_done), .USR_RDATA(usr_rdata));
    snmsp_checker snmsp_checker_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .sck(bus.sck),
        .cs_n(bus.cs_n), .si(bus.si), .so(bus.so), .so_oe_n(bus.so_oe_n),
        .hold_n(bus.hold_n), .wp_n(bus.wp_n));
    // data-out as a joined data line would see it
    wire so_line;
    assign so_line = bus.so_oe_n ? 1'bz : bus.so;

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic launch(input logic [47:0] r);
        int k;
        k = 0;
        while (usr_busy !== 1'b0 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 100) begin
            n_mismatch++;
            finish_test();
        end
        usr_cmd = r[47:40];
        usr_addr = r[39:24];
        usr_wdata = r[23:16];
        usr_wp_n = r[4];
        usr_start = 1'b1;
        @(negedge core_clk);
        usr_start = 1'b0;
    endtask

    // bound covers a 32-bit frame plus a long pause
    task automatic wait_done();
        int k;
        k = 0;
        while (usr_done !== 1'b1 && k < 4000) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 4000) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    task automatic do_cmd(input logic [47:0] r);
        launch(r);
        wait_done();
    endtask

    task automatic hit_reset();
        sys_rst = 1'b1;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        usr_start = 1'b0;
        usr_pause = 1'b0;
        usr_wp_n = 1'b1;
        usr_cmd = 8'h00;
        usr_addr = 16'h0000;
        usr_wdata = 8'h00;
        sys_rst = 1'b1;
        hit_reset();
        for (int i = 0; i < NROWS; i++) begin
            do_cmd(rows[i]);
            if (rows[i][0]) begin
                check(usr_rdata, rows[i][15:8]);
            end
        end
        // pause in mid data byte, then resume
        launch(48'h030010000000);
        repeat (228) @(negedge core_clk);
        check({7'h00, bus.so_oe_n}, 8'h00);
        usr_pause = 1'b1;
        repeat (30) @(negedge core_clk);
        check({7'h00, bus.so_oe_n}, 8'h01);
        check({7'h00, paused}, 8'h01);
        repeat (30) @(negedge core_clk);
        usr_pause = 1'b0;
        wait_done();
        check(usr_rdata, 8'h5A);
        check({7'h00, so_line === 1'bz}, 8'h01);
        check({7'h00, selected}, 8'h00);
        // leave a protect setting, then a second reset must clear it
        do_cmd(48'h060000000010);
        do_cmd(48'h010000080010);
        check(status, 8'h08);
        hit_reset();
        check(status, 8'h00);
        check({7'h00, usr_busy}, 8'h00);
        check({6'h00, bus.cs_n, bus.so_oe_n}, 8'h03);
        finish_test();
    end
endmodule
